// ==== logic/csp_cal_rom.sv ====
// Factory calibration byte store, one byte each for the 4.8 and 9.6 MHz modes.
// Assumes a synchronous clock; read data come from a register.
`timescale 1ns/100ps
`include "csp_params.svh"
module csp_cal_rom (
   input  wire logic       clk,
   input  wire logic [0:0] rd_addr,
   input  wire logic [6:0] cal_48,
   input  wire logic [6:0] cal_96,
   output logic      [6:0] rd_data_q
);
   logic [6:0] mem [`CSP_CAL_ROWS];
   assign mem[0] = cal_48;
   assign mem[1] = cal_96;
   always_ff @(posedge clk) begin
      rd_data_q <= mem[rd_addr];
   end
endmodule // csp_cal_rom

// ==== logic/csp_clock_ctrl.sv ====
// System clock control: source choice, start-up delay, prescaler, trim.
// Assumes fuses and calibration bytes are static inputs from the fuse array.
`timescale 1ns/100ps
`include "csp_params.svh"
// Overview of operation
// RQ1: Source fuse 10 gives 9.6 MHz trimmed oscillator, 01 gives 4.8 MHz.
// RQ2: Source fuse 11 selects the 128 kHz low-power oscillator.
// RQ3: Each reset loads the one calibration byte matching the mode into trim.
// RQ4: 4.8 and 9.6 MHz share the oscillator; only a divider differs.
// RQ5: Watchdog and reset time-out stay timed by watchdog oscillator.
// RQ6: Trimmed source: wake 6 clocks; reset delay 14, +4 ms, +64 ms.
// RQ7: 128 kHz source uses the same start-up codes and timing.
// RQ8: Reset-pin-disable fuse stretches shortest delay to 14 clocks plus 4 ms.
// RQ9: Defaults are source 10, start-up 10, divide-by-eight programmed.
// RQ10: Prescaler divides core, flash, I/O and converter clocks together.
// RQ11: Prescale change gives no glitch and no faster intermediate clock.
// RQ12: New rate takes effect after two active edges.
// RQ13: Prescaler is a counter at undivided rate with hidden state.
// RQ14: Trim register at 0x31 holds 7 writable bits, top bit reads zero.
// RQ15: Trim zero is slowest, larger values faster, 0x7F fastest.
// RQ16: Software trims only toward 9.6 or 4.8 MHz.
// RQ17: Software keeps trim within 10% above nominal while writing memories.
// RQ18: Software changes trim in steps no larger than 0x20.
// RQ19: Software programs divide-by-eight when oscillator exceeds supply limit.
// RQ20: Prescale code 0000 to 1000 divides by 1 to 256; above reserved.
// RQ21: Unlock written alone, then prescale value within four cycles.
// RQ22: Reset loads prescale 0011 if divide-by-eight programmed, else 0000.
// RQ23: Trim writes act directly and hold until next write or reset.
module csp_clock_ctrl
   import csp_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire csp_pkg::csp_fuses_s  fuses,
   input  wire logic [6:0]           cal_byte_48,
   input  wire logic [6:0]           cal_byte_96,
   input  wire logic                 wdt_osc_tick,
   input  wire logic                 wake_req,
   input  wire csp_pkg::csp_bus_s    bus,
   output logic      [7:0]           rdata_q,
   output logic      [6:0]           osc_trim_q,
   output logic      [1:0]           osc_source_q,
   output logic                      osc_half_q,
   output logic      [3:0]           prescale_select_q,
   output logic                      sys_clk_en,
   output logic                      startup_done_q
);
   import csp_pkg::*;

   csp_state_e  state_q;
   csp_fuses_s  fuses_q;
   logic [1:0]  tick_sync_q;
   logic        tick_prev_q;
   logic        tick_rise;
   logic [7:0]  ck_cnt_q;
   logic [13:0] wdt_cnt_q;
   logic [13:0] wdt_target;
   logic [3:0]  ps_active_q;
   logic [3:0]  ps_pending_q;
   logic        ps_change_q;
   logic [1:0]  ps_edges_q;
   logic [7:0]  ripple_q;
   logic        div_tick;
   logic        unlock_q;
   logic [2:0]  unlock_cnt_q;
   logic        wake_sync0_q;
   logic        wake_sync1_q;
   logic        wake_prev_q;
   logic        wake_rise;
   logic        waking_q;
   logic [6:0]  cal_rd;
   logic        cal_load_q;

   function automatic logic is_wr(input csp_bus_s b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction

   // Tick when the low ps counter bits are all ones
   function automatic logic tap_of(input logic [7:0] r, input logic [3:0] ps);
      logic [7:0] m;
      m = 8'((9'h001 << ps) - 9'h001);
      return ((r & m) == m);
   endfunction

   // Fuse capture after reset release
   always_ff @(posedge clk) begin
      if (srst) begin
         fuses_q <= '0;
      end else if (state_q == CSP_ST_RESET) begin
         fuses_q <= fuses;
      end
   end

   // RQ1 RQ2 source decode
   always_ff @(posedge clk) begin
      if (srst) begin
         osc_source_q <= `CSP_SRC_RC96;
         osc_half_q   <= 1'b0;
      end else begin
         osc_source_q <= fuses_q.clock_source_select_fuses;
         // RQ4 shared oscillator divider
         osc_half_q   <= (fuses_q.clock_source_select_fuses == `CSP_SRC_RC48);
      end
   end

   // RQ3 calibration byte select
   csp_cal_rom u_cal_rom (
      .clk       (clk),
      .rd_addr   (fuses.clock_source_select_fuses == `CSP_SRC_RC96),
      .cal_48    (cal_byte_48),
      .cal_96    (cal_byte_96),
      .rd_data_q (cal_rd)
   );

   // Watchdog oscillator tick and wake request synchronisers
   always_ff @(posedge clk) begin
      if (srst) begin
         tick_sync_q  <= 2'b00;
         tick_prev_q  <= 1'b0;
         wake_sync0_q <= 1'b0;
         wake_sync1_q <= 1'b0;
         wake_prev_q  <= 1'b0;
      end else begin
         tick_sync_q  <= {tick_sync_q[0], wdt_osc_tick};
         tick_prev_q  <= tick_sync_q[1];
         wake_sync0_q <= wake_req;
         wake_sync1_q <= wake_sync0_q;
         wake_prev_q  <= wake_sync1_q;
      end
   end
   assign tick_rise = tick_sync_q[1] & ~tick_prev_q;
   assign wake_rise = wake_sync1_q & ~wake_prev_q;

   // RQ6 RQ7 RQ8 watchdog time-out choice
   always_comb begin
      wdt_target = 14'h0000;
      case (fuses_q.startup_time_fuses)
         `CSP_SUT_SHORT: wdt_target = fuses_q.reset_pin_disable_fuse ? `CSP_WDT_4MS : 14'h0000;
         `CSP_SUT_4MS:   wdt_target = `CSP_WDT_4MS;
         `CSP_SUT_64MS:  wdt_target = `CSP_WDT_64MS;
         default:        wdt_target = `CSP_WDT_64MS;
      endcase
   end

   // RQ5 reset sequence
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q        <= CSP_ST_RESET;
         wdt_cnt_q      <= 14'h0000;
         ck_cnt_q       <= 8'h00;
         startup_done_q <= 1'b0;
         cal_load_q     <= 1'b0;
      end else begin
         cal_load_q <= 1'b0;
         case (state_q)
            CSP_ST_RESET: begin
               state_q    <= CSP_ST_WDT;
               wdt_cnt_q  <= 14'h0000;
               cal_load_q <= 1'b1;
            end
            CSP_ST_WDT: begin
               // RQ5 watchdog oscillator timed
               if (wdt_cnt_q >= wdt_target) begin
                  state_q  <= CSP_ST_CLK;
                  ck_cnt_q <= 8'h00;
               end else if (tick_rise) begin
                  wdt_cnt_q <= wdt_cnt_q + 14'h0001;
               end
            end
            CSP_ST_CLK: begin
               // RQ6 RQ7 fourteen clock count
               if (ck_cnt_q == `CSP_RESET_CK - 8'h01) begin
                  state_q        <= CSP_ST_RUN;
                  startup_done_q <= 1'b1;
               end else begin
                  ck_cnt_q <= ck_cnt_q + 8'h01;
               end
            end
            CSP_ST_RUN: begin
               // RQ6 six clock wake
               if (wake_rise && !waking_q) begin
                  startup_done_q <= 1'b0;
                  ck_cnt_q       <= 8'h00;
               end else if (waking_q) begin
                  if (ck_cnt_q == `CSP_WAKE_CK - 8'h01) begin
                     startup_done_q <= 1'b1;
                  end else begin
                     ck_cnt_q <= ck_cnt_q + 8'h01;
                  end
               end
            end
            default: state_q <= CSP_ST_RESET;
         endcase
      end
   end
   assign waking_q = (state_q == CSP_ST_RUN) && !startup_done_q;

   // RQ23 trim write and hold
   always_ff @(posedge clk) begin
      if (srst) begin
         osc_trim_q <= 7'h00;
      end else if (cal_load_q) begin
         // RQ3 reset reload
         osc_trim_q <= cal_rd;
      end else if (is_wr(bus, `CSP_ADDR_TRIM)) begin
         // RQ14 RQ15 seven bit trim
         osc_trim_q <= bus.wdata[6:0];
      end
   end

   // RQ21 unlock window
   always_ff @(posedge clk) begin
      if (srst) begin
         unlock_q     <= 1'b0;
         unlock_cnt_q <= 3'h0;
      end else if (is_wr(bus, `CSP_ADDR_PRESCALE) && unlock_q && !bus.wdata[`CSP_UNLOCK_BIT]) begin
         unlock_q <= 1'b0;
      end else if (unlock_q) begin
         if (unlock_cnt_q == `CSP_UNLOCK_WINDOW - 3'h1) begin
            unlock_q <= 1'b0;
         end else begin
            unlock_cnt_q <= unlock_cnt_q + 3'h1;
         end
      end else if (is_wr(bus, `CSP_ADDR_PRESCALE) && bus.wdata == 8'h80) begin
         unlock_q     <= 1'b1;
         unlock_cnt_q <= 3'h0;
      end
   end

   // RQ22 RQ20 prescale select
   always_ff @(posedge clk) begin
      if (srst) begin
         prescale_select_q <= `CSP_PS_DIV8;
      end else if (state_q == CSP_ST_RESET) begin
         prescale_select_q <= fuses.divide_by_eight_fuse ? `CSP_PS_DIV8 : `CSP_PS_DIV1;
      end else if (is_wr(bus, `CSP_ADDR_PRESCALE) && unlock_q && !bus.wdata[`CSP_UNLOCK_BIT]
                   && bus.wdata[3:0] <= `CSP_PS_MAX) begin
         prescale_select_q <= bus.wdata[3:0];
      end
   end

   // RQ13 undivided counter
   always_ff @(posedge clk) begin
      if (srst) begin
         ripple_q <= 8'h00;
      end else begin
         ripple_q <= ripple_q + 8'h01;
      end
   end

   // RQ11 RQ12 switch on two edges
   always_ff @(posedge clk) begin
      if (srst) begin
         ps_active_q  <= `CSP_PS_DIV8;
         ps_pending_q <= `CSP_PS_DIV8;
         ps_change_q  <= 1'b0;
         ps_edges_q   <= 2'h0;
      end else if (state_q == CSP_ST_RESET) begin
         ps_active_q <= fuses.divide_by_eight_fuse ? `CSP_PS_DIV8 : `CSP_PS_DIV1;
         ps_change_q <= 1'b0;
      end else if (prescale_select_q != ps_pending_q) begin
         ps_pending_q <= prescale_select_q;
         ps_change_q  <= 1'b1;
         ps_edges_q   <= 2'h0;
      end else if (ps_change_q && div_tick) begin
         if (ps_edges_q == 2'h0) begin
            ps_active_q <= (ps_pending_q > ps_active_q) ? ps_pending_q : ps_active_q;
            ps_edges_q  <= 2'h1;
         end else begin
            ps_active_q <= ps_pending_q;
            ps_change_q <= 1'b0;
         end
      end
   end
   assign div_tick = tap_of(ripple_q, ps_active_q);

   // RQ10 common clock enable
   assign sys_clk_en = div_tick && startup_done_q;

   // Register read port
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            `CSP_ADDR_TRIM:        rdata_q <= {1'b0, osc_trim_q};
            `CSP_ADDR_PRESCALE:    rdata_q <= {unlock_q, 3'b000, prescale_select_q};
            `CSP_ADDR_FUSE_STATUS: rdata_q <= {2'b00, fuses_q};
            `CSP_ADDR_RUN_STATUS:  rdata_q <= {4'h0, ps_change_q, startup_done_q, state_q};
            default:               rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
endmodule // csp_clock_ctrl

// ==== logic/csp_params.svh ====
// Constants for the clock source, prescaler and trim block.
// Assumes inclusion by the package, the main module and the calibration byte store.
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH
`define CSP_ADDR_TRIM        8'h31
`define CSP_ADDR_PRESCALE    8'h26
`define CSP_ADDR_FUSE_STATUS 8'h27
`define CSP_ADDR_RUN_STATUS  8'h28
`define CSP_UNLOCK_BIT       7
`define CSP_UNLOCK_WINDOW    3'h4
`define CSP_PS_MAX           4'h8
`define CSP_PS_DIV8          4'h3
`define CSP_PS_DIV1          4'h0
`define CSP_SRC_EXT          2'h0
`define CSP_SRC_RC48         2'h1
`define CSP_SRC_RC96         2'h2
`define CSP_SRC_LP128        2'h3
`define CSP_SUT_SHORT        2'h0
`define CSP_SUT_4MS          2'h1
`define CSP_SUT_64MS         2'h2
`define CSP_WAKE_CK          8'h06
`define CSP_RESET_CK         8'h0e
`define CSP_WDT_4MS          14'h0200
`define CSP_WDT_64MS         14'h2000
`define CSP_CAL_ROWS         2
`endif

// ==== logic/csp_pkg.sv ====
// Types for the clock source, prescaler and trim block.
// Assumes csp_params.svh is on the include path.
`include "csp_params.svh"
package csp_pkg;
   typedef enum logic [1:0] {
      CSP_ST_RESET = 2'b00,
      CSP_ST_WDT   = 2'b01,
      CSP_ST_CLK   = 2'b10,
      CSP_ST_RUN   = 2'b11
   } csp_state_e;
   typedef struct packed {
      logic [1:0] clock_source_select_fuses;
      logic [1:0] startup_time_fuses;
      logic       divide_by_eight_fuse;
      logic       reset_pin_disable_fuse;
   } csp_fuses_s;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } csp_bus_s;
endpackage : csp_pkg

// ==== sim/clock_source_prescaler_trim_test.sv ====
// Self-checking bench for the clock source, prescaler and trim block.
// Assumes design files and checker are compiled before it.
`timescale 1ns/100ps
module clock_source_prescaler_trim_test;
   import csp_pkg::*;
   logic       clk;
   logic       srst;
   logic       wake_req;
   logic [1:0] tdiv;
   csp_fuses_s fuses;
   csp_bus_s   bus;
   logic [7:0] rdata_q;
   logic [7:0] rv;
   logic [6:0] osc_trim_q;
   logic [1:0] osc_source_q;
   logic       osc_half_q;
   logic [3:0] prescale_select_q;
   logic       sys_clk_en;
   logic       startup_done_q;
   int         num_errors;
   int         n_tests;
   int         cyc;
   int         n;
   csp_clock_ctrl uut (.clk(clk), .srst(srst), .fuses(fuses), .cal_byte_48(7'h2a), .cal_byte_96(7'h55),
      .wdt_osc_tick(tdiv[1]), .wake_req(wake_req), .bus(bus), .rdata_q(rdata_q), .osc_trim_q(osc_trim_q),
      .osc_source_q(osc_source_q), .osc_half_q(osc_half_q), .prescale_select_q(prescale_select_q),
      .sys_clk_en(sys_clk_en), .startup_done_q(startup_done_q));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One bus cycle, then one idle cycle
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
      bus <= {a, d, w, !w};
      @(posedge clk);
      bus <= '0;
      #1;
      rv = rdata_q;
      @(posedge clk);
   endtask
   task automatic start(input csp_fuses_s f);
      fuses <= f;
      srst  <= 1'b1;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      n = 0;
      while (startup_done_q !== 1'b1 && n < 40000) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Watchdog tick every four clocks, and hang guard
   always @(posedge clk) begin
      tdiv <= tdiv + 2'h1;
      cyc++;
      if (cyc == 90000) begin
         num_errors++;
         report_and_stop;
      end
   end
   initial begin
      srst     = 1'b1;
      wake_req = 1'b0;
      bus      = '0;
      fuses    = '0;
      tdiv     = 2'h0;
      // divide-by-eight kept programmed for the fast source
      start({2'h2, 2'h2, 1'b1, 1'b0});
      chk(n >= 32768, 1'b1);
      chk(osc_trim_q, 7'h55);
      chk(osc_source_q, 2'h2);
      chk(osc_half_q, 1'b0);
      xfer(8'h26, 8'h00, 1'b0);
      chk(rv, 8'h03);
      // trim stepped by at most 0x20, no memory writes
      xfer(8'h31, 8'hf5, 1'b1);
      xfer(8'h31, 8'h00, 1'b0);
      chk(rv, 8'h75);
      xfer(8'h31, 8'hff, 1'b1);
      xfer(8'h31, 8'h00, 1'b0);
      chk(rv, 8'h7f);
      chk(osc_trim_q, 7'h7f);
      xfer(8'h26, 8'h01, 1'b1);
      xfer(8'h26, 8'h00, 1'b0);
      chk(rv, 8'h03);
      xfer(8'h26, 8'h80, 1'b1);
      repeat (2) @(posedge clk);
      xfer(8'h26, 8'h02, 1'b1);
      xfer(8'h26, 8'h00, 1'b0);
      chk(rv, 8'h02);
      xfer(8'h26, 8'h80, 1'b1);
      repeat (3) @(posedge clk);
      xfer(8'h26, 8'h01, 1'b1);
      xfer(8'h26, 8'h00, 1'b0);
      chk(rv, 8'h02);
      xfer(8'h26, 8'h80, 1'b1);
      xfer(8'h26, 8'h09, 1'b1);
      xfer(8'h26, 8'h00, 1'b0);
      chk(rv, 8'h02);
      for (int k = 0; k <= 8; k++) begin
         xfer(8'h26, 8'h80, 1'b1);
         xfer(8'h26, 8'(k), 1'b1);
         repeat (700) @(posedge clk);
         n = 0;
         repeat (1024) begin
            @(posedge clk);
            #1;
            n += sys_clk_en;
         end
         chk(n, 1024 >> k);
      end
      @(posedge clk);
      wake_req <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk(startup_done_q, 1'b0);
      @(posedge clk);
      #1;
      chk(startup_done_q, 1'b1);
      repeat (20) @(posedge clk);
      #1;
      chk(startup_done_q, 1'b1);
      @(posedge clk);
      wake_req <= 1'b0;
      start({2'h1, 2'h0, 1'b0, 1'b1});
      chk(n >= 2048 && n < 8192, 1'b1);
      chk(osc_trim_q, 7'h2a);
      chk(osc_half_q, 1'b1);
      chk(prescale_select_q, 4'h0);
      start({2'h3, 2'h0, 1'b0, 1'b0});
      chk(n >= 14 && n < 64, 1'b1);
      chk(osc_source_q, 2'h3);
      report_and_stop;
   end
endmodule // clock_source_prescaler_trim_test

// ==== sim/csp_clock_ctrl_properties.sv ====
// Port checks for the clock source, prescaler and trim block.
// Assumes a bind to csp_clock_ctrl; one clock, sync reset.
`timescale 1ns/100ps
module csp_clock_ctrl_properties
   import csp_pkg::*;
(
   input wire logic                clk,
   input wire logic                srst,
   input wire csp_pkg::csp_fuses_s fuses,
   input wire logic [6:0]          cal_byte_48,
   input wire logic [6:0]          cal_byte_96,
   input wire csp_pkg::csp_bus_s   bus,
   input wire logic [7:0]          rdata_q,
   input wire logic [6:0]          osc_trim_q,
   input wire logic [1:0]          osc_source_q,
   input wire logic                osc_half_q,
   input wire logic [3:0]          prescale_select_q,
   input wire logic                sys_clk_en,
   input wire logic                startup_done_q
);
   logic [2:0] win_q;
   logic       ps_wr;
   logic       take;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   assign ps_wr = bus.wr && bus.addr == 8'h26;
   assign take  = ps_wr && win_q != 3'h0 && !bus.wdata[7] && bus.wdata[3:0] <= 4'h8;
   // Unlock window tracker
   always_ff @(posedge clk) begin
      if (srst) win_q <= 3'h0;
      else if (ps_wr && bus.wdata == 8'h80 && win_q == 3'h0) win_q <= 3'h4;
      else if (ps_wr && bus.wdata != 8'h80) win_q <= 3'h0;
      else if (win_q != 3'h0) win_q <= win_q - 3'h1;
   end
   ps_take_a: assert property (take |=> prescale_select_q == $past(bus.wdata[3:0]))
      else $error("Prescale value not taken");
   ps_hold_a: assert property (!$past(take) && !$past(srst) && !$past(srst, 2) && !$past(srst, 3) |-> $stable(prescale_select_q))
      else $error("Prescale changed without unlock");
   ps_range_a: assert property (prescale_select_q <= 4'h8)
      else $error("Reserved prescale code held");
   ps_init_a: assert property ($fell(srst) |-> ##[1:3] prescale_select_q == (fuses.divide_by_eight_fuse ? 4'h3 : 4'h0))
      else $error("Prescale reset value wrong");
   trim_init_a: assert property ($fell(srst) |-> ##[1:3] osc_trim_q == (fuses.clock_source_select_fuses == 2'h2 ? cal_byte_96 : cal_byte_48))
      else $error("Calibration byte not loaded");
   trim_wr_a: assert property (bus.wr && bus.addr == 8'h31 |=> osc_trim_q == $past(bus.wdata[6:0]))
      else $error("Trim write not applied");
   trim_rd_a: assert property (bus.rd && bus.addr == 8'h31 |=> rdata_q == {1'b0, $past(osc_trim_q)})
      else $error("Trim read value wrong");
   rd_idle_a: assert property (!$past(bus.rd) |-> rdata_q == 8'h00)
      else $error("Read data outside read cycle");
   src_sel_a: assert property ($fell(srst) |-> ##[1:3] osc_source_q == fuses.clock_source_select_fuses)
      else $error("Source code not from fuses");
   half_mode_a: assert property (!$past(srst) && !$past(srst, 2) |-> osc_half_q == (osc_source_q == 2'h1))
      else $error("Half rate flag wrong");
   en_gate_a: assert property (!startup_done_q |-> !sys_clk_en)
      else $error("Clock enable before start-up");
   boot_min_a: assert property ($fell(srst) |-> !startup_done_q [*8])
      else $error("Start-up finished too early");
endmodule // csp_clock_ctrl_properties
bind csp_clock_ctrl csp_clock_ctrl_properties props (.clk(clk), .srst(srst), .fuses(fuses),
   .cal_byte_48(cal_byte_48), .cal_byte_96(cal_byte_96), .bus(bus), .rdata_q(rdata_q),
   .osc_trim_q(osc_trim_q), .osc_source_q(osc_source_q), .osc_half_q(osc_half_q),
   .prescale_select_q(prescale_select_q), .sys_clk_en(sys_clk_en), .startup_done_q(startup_done_q));
